/* File: rtl/ssm_consts.svh */
// Offsets, field positions, reset values and timing counts for the supply channel controller.
// Assumes inclusion by bare name from the design file and the bench.
`ifndef SSM_CONSTS_SVH
`define SSM_CONSTS_SVH

// Register offsets (word addresses on the plain register port)
`define SSM_A_CTRL      8'h00
`define SSM_A_ONOFF     8'h01
`define SSM_A_SERVO     8'h02
`define SSM_A_VCMD      8'h03
`define SSM_A_MHI       8'h04
`define SSM_A_MLO       8'h05
`define SSM_A_OVF       8'h06
`define SSM_A_OVW       8'h07
`define SSM_A_UVW       8'h08
`define SSM_A_UVF       8'h09
`define SSM_A_VINON     8'h0a
`define SSM_A_VINOFF    8'h0b
`define SSM_A_TON       8'h0c
`define SSM_A_TRISE     8'h0d
`define SSM_A_TMAX      8'h0e
`define SSM_A_TOFF      8'h0f
`define SSM_A_DAC       8'h10
`define SSM_A_DISCH     8'h11
`define SSM_A_STATUS    8'h12
`define SSM_A_CLEAR     8'h13

// Control register fields
`define SSM_CTRL_CFG_LO 0
`define SSM_CTRL_CHMODE 2
`define SSM_CTRL_TOFAIL 3
// On/off command fields: bit 7 on, bits 5:4 margin select
`define SSM_OP_ON       7
`define SSM_OP_MG_HI    5
`define SSM_OP_MG_LO    4
// Servo configuration fields
`define SSM_SV_CONT     7
`define SSM_SV_WARN     6
`define SSM_SV_FASTOFF  5
`define SSM_SV_DMODE_LO 0
// Status bits
`define SSM_ST_TON_TO   0
`define SSM_ST_OV       1
`define SSM_ST_DECAY    2
`define SSM_ST_ON       3
`define SSM_ST_CONN     4

// Reset values
`define SSM_SERVO_RST   8'h00
`define SSM_CTRL_RST    8'h00

// Time base and near-target window
`define SSM_TICK_NS     1000
`define SSM_CLK_NS      5
`define SSM_FAST_NS     1000
`define SSM_NEAR_CODES  4

`endif

/* File: rtl/ssm_pkg.sv */
// Types shared by the supply channel controller.
// Assumes the constants header sits beside it.
package ssm_pkg;

  // Channel sequencing states
  typedef enum logic [2:0] {
    SEQ_OFF   = 3'b000,
    SEQ_TOND  = 3'b001,
    SEQ_RISE  = 3'b010,
    SEQ_ON    = 3'b011,
    SEQ_TOFFD = 3'b100
  } ssm_seq_t;

  // Turn-on condition select
  typedef enum logic [1:0] {
    CFG_VIN     = 2'b00,
    CFG_CMD     = 2'b01,
    CFG_PIN     = 2'b10,
    CFG_CMD_PIN = 2'b11
  } ssm_oncfg_t;

  // DAC connection mode
  typedef enum logic [1:0] {
    DAC_SERVO  = 2'b00,
    DAC_OPEN   = 2'b01,
    DAC_MAN_SC = 2'b10,
    DAC_MAN_HC = 2'b11
  } ssm_dmode_t;

endpackage

/* File: rtl/ssm_channel.sv */
// One supply channel: on/off gating, timed sequencing, supervision and DAC servo.
// Assumes conversions arrive as strobed codes synchronous to core_clk at 200 MHz.
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "ssm_consts.svh"

module ssm_channel #(
  parameter int CW = 16,
  parameter int DW = 10
) (
  // Clock, reset, enable
  input  wire logic          core_clk,
  input  wire logic          nrst,
  input  wire logic          clk_en,
  // Register port
  input  wire logic [7:0]    reg_addr,
  input  wire logic [15:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [15:0]   reg_rdata,
  // Measurements
  input  wire logic [CW-1:0] input_voltage_sense,
  input  wire logic          vin_valid,
  input  wire logic [CW-1:0] vout_code,
  input  wire logic          vout_valid,
  input  wire logic [DW-1:0] feedback_code,
  input  wire logic          control_pin,
  input  wire logic          margin_ov_ignore,
  // Converter side
  output logic               vout_enable,
  output logic      [DW-1:0] dac_code,
  output logic               trim_dac_output_oe_n,
  // Shared fault line (open drain) and alert
  input  wire logic          shared_fault_line_in,
  output logic               shared_fault_line_out,
  output logic               shared_fault_line_oe_n,
  output logic               alert_line_n
);

  localparam int TICK_N = (`SSM_TICK_NS + `SSM_CLK_NS - 1) / `SSM_CLK_NS;
  localparam int FAST_N = (`SSM_FAST_NS + `SSM_CLK_NS - 1) / `SSM_CLK_NS;

  // ****************************************
  // Reset synchroniser and registers
  // ****************************************
  logic rs1_r, rst_n;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rs1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rst_n <= rs1_r;
    end
  end

  logic [7:0]    ctrl_r, onoff_r, servo_r;
  logic [CW-1:0] vcmd_r, mhi_r, mlo_r, ovf_r, ovw_r, uvw_r, uvf_r, vinon_r, vinoff_r;
  logic [15:0]   ton_r, trise_r, tmax_r, toff_r;
  logic [7:0]    disch_r;
  logic [DW-1:0] dac_reg_r;
  logic          dac_wr;
  logic          clr_faults;
  assign dac_wr     = clk_en && reg_wr && reg_addr == `SSM_A_DAC;
  assign clr_faults = clk_en && reg_wr && reg_addr == `SSM_A_CLEAR;

  // Software writes; all values hold while the clock enable is low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `SSM_CTRL_RST; onoff_r <= 8'h00; servo_r <= `SSM_SERVO_RST;
      vcmd_r <= '0; mhi_r <= '0; mlo_r <= '0; ovf_r <= '1; ovw_r <= '1;
      uvw_r <= '0; uvf_r <= '0; vinon_r <= '0; vinoff_r <= '0;
      ton_r <= 16'h0000; trise_r <= 16'h0000; tmax_r <= 16'hffff; toff_r <= 16'h0000;
      disch_r <= 8'h00; dac_reg_r <= '0;
    end else if (clk_en && reg_wr) begin
      case (reg_addr)
        `SSM_A_CTRL:   ctrl_r    <= reg_wdata[7:0];
        `SSM_A_ONOFF:  onoff_r   <= reg_wdata[7:0];
        `SSM_A_SERVO:  servo_r   <= reg_wdata[7:0];
        `SSM_A_VCMD:   vcmd_r    <= reg_wdata[CW-1:0];
        `SSM_A_MHI:    mhi_r     <= reg_wdata[CW-1:0];
        `SSM_A_MLO:    mlo_r     <= reg_wdata[CW-1:0];
        `SSM_A_OVF:    ovf_r     <= reg_wdata[CW-1:0];
        `SSM_A_OVW:    ovw_r     <= reg_wdata[CW-1:0];
        `SSM_A_UVW:    uvw_r     <= reg_wdata[CW-1:0];
        `SSM_A_UVF:    uvf_r     <= reg_wdata[CW-1:0];
        `SSM_A_VINON:  vinon_r   <= reg_wdata[CW-1:0];
        `SSM_A_VINOFF: vinoff_r  <= reg_wdata[CW-1:0];
        `SSM_A_TON:    ton_r     <= reg_wdata;
        `SSM_A_TRISE:  trise_r   <= reg_wdata;
        `SSM_A_TMAX:   tmax_r    <= reg_wdata;
        `SSM_A_TOFF:   toff_r    <= reg_wdata;
        `SSM_A_DISCH:  disch_r   <= reg_wdata[7:0];
        `SSM_A_DAC:    dac_reg_r <= reg_wdata[DW-1:0];
        default: ;
      endcase
    end
  end

  // ****************************************
  // Input supervision and on/off decision
  // ****************************************
  logic vin_ok_r;
  // Hysteresis between on and off thresholds
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) vin_ok_r <= 1'b0;
    else if (clk_en && vin_valid) begin
      if (input_voltage_sense > vinon_r) vin_ok_r <= 1'b1;
      else if (input_voltage_sense < vinoff_r) vin_ok_r <= 1'b0;
    end
  end

  ssm_pkg::ssm_oncfg_t oncfg;
  logic on_req;
  assign oncfg = ssm_pkg::ssm_oncfg_t'(ctrl_r[`SSM_CTRL_CFG_LO +: 2]);
  // Turn-on condition selection, gated by the input threshold
  always_comb begin
    case (oncfg)
      ssm_pkg::CFG_VIN: on_req = 1'b1;
      ssm_pkg::CFG_CMD: on_req = onoff_r[`SSM_OP_ON];
      ssm_pkg::CFG_PIN: on_req = control_pin;
      default:          on_req = onoff_r[`SSM_OP_ON] && control_pin;
    endcase
    on_req = on_req && vin_ok_r;
  end

  // Off threshold; product truncated back to code width on purpose
  logic [CW+7:0] off_prod;
  logic          decayed;
  assign off_prod = vcmd_r * disch_r;
  assign decayed  = vout_code < off_prod[CW+7:8];

  // ****************************************
  // Sequencer with common time base
  // ****************************************
  logic [15:0] tick_cnt_r;
  logic        tick;
  assign tick = tick_cnt_r == 16'(TICK_N - 1);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) tick_cnt_r <= 16'h0000;
    else if (clk_en) tick_cnt_r <= tick ? 16'h0000 : tick_cnt_r + 16'h0001;
  end

  ssm_pkg::ssm_seq_t st_r;
  logic [15:0] cnt_r, tmax_cnt_r, rise_lat_r, tmax_lat_r;
  logic        to_fault_r, ov_fault_r, decay_flag_r, to_off_r, connect_req_r;
  logic        uv_now, ov_now, fault_line_low, fault_off;
  assign uv_now = vout_code < uvf_r;
  assign ov_now = vout_code > ovf_r;
  assign fault_off = to_fault_r && ctrl_r[`SSM_CTRL_TOFAIL];
  assign fault_line_low = !shared_fault_line_in && !fault_off;

  // One machine per channel; on, rise and max delays latched as the on delay begins, off delay as it begins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ssm_pkg::SEQ_OFF; cnt_r <= 16'h0000; tmax_cnt_r <= 16'h0000;
      rise_lat_r <= 16'h0000; tmax_lat_r <= 16'h0000; connect_req_r <= 1'b0;
    end else if (clk_en) begin
      connect_req_r <= 1'b0;
      if (st_r != ssm_pkg::SEQ_OFF && tick && tmax_cnt_r != 16'hffff)
        tmax_cnt_r <= tmax_cnt_r + 16'h0001;
      case (st_r)
        ssm_pkg::SEQ_OFF: begin
          if (on_req && decayed && !fault_line_low && !to_off_r) begin
            st_r       <= ssm_pkg::SEQ_TOND;
            cnt_r      <= ton_r;
            rise_lat_r <= trise_r;
            tmax_lat_r <= tmax_r;
            tmax_cnt_r <= 16'h0000;
          end
        end
        ssm_pkg::SEQ_TOND: begin
          if (!on_req || fault_line_low) st_r <= ssm_pkg::SEQ_OFF;
          else if (cnt_r == 16'h0000) begin
            st_r  <= ssm_pkg::SEQ_RISE;
            cnt_r <= rise_lat_r;
          end else if (tick) cnt_r <= cnt_r - 16'h0001;
        end
        // An off request during rise starts the off delay at once, not after the rise
        ssm_pkg::SEQ_RISE, ssm_pkg::SEQ_ON: begin
          if (!on_req) begin
            st_r  <= ssm_pkg::SEQ_TOFFD;
            cnt_r <= toff_r;
          end else if (st_r == ssm_pkg::SEQ_RISE && cnt_r == 16'h0000) begin
            st_r          <= ssm_pkg::SEQ_ON;
            connect_req_r <= 1'b1;
          end else if (st_r == ssm_pkg::SEQ_RISE && tick) cnt_r <= cnt_r - 16'h0001;
        end
        ssm_pkg::SEQ_TOFFD: begin
          if (cnt_r == 16'h0000) st_r <= ssm_pkg::SEQ_OFF;
          else if (tick) cnt_r <= cnt_r - 16'h0001;
        end
        default: st_r <= ssm_pkg::SEQ_OFF;
      endcase
      // Immediate off on input loss unless in delayed-off mode, on fault line outside the off delay, or on timeout shutdown
      if ((!vin_ok_r && !ctrl_r[`SSM_CTRL_CHMODE]) || fault_off ||
          (fault_line_low && st_r != ssm_pkg::SEQ_TOFFD))
        st_r <= ssm_pkg::SEQ_OFF;
    end
  end

  assign vout_enable = st_r == ssm_pkg::SEQ_RISE || st_r == ssm_pkg::SEQ_ON ||
                       st_r == ssm_pkg::SEQ_TOFFD;

  // Fault flags: set wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      to_fault_r <= 1'b0; ov_fault_r <= 1'b0; decay_flag_r <= 1'b0; to_off_r <= 1'b0;
    end else if (clk_en) begin
      if (st_r != ssm_pkg::SEQ_OFF && st_r != ssm_pkg::SEQ_TOFFD &&
          tmax_cnt_r == tmax_lat_r && uv_now)
        to_fault_r <= 1'b1;
      else if (clr_faults) to_fault_r <= 1'b0;
      if (ov_now && !(margin_ov_ignore && onoff_r[`SSM_OP_MG_HI +: 2] != 2'b00))
        ov_fault_r <= 1'b1;
      else if (clr_faults) ov_fault_r <= 1'b0;
      if (st_r == ssm_pkg::SEQ_OFF && on_req && !decayed) decay_flag_r <= 1'b1;
      else if (clr_faults) decay_flag_r <= 1'b0;
      // Latched off until the on request is withdrawn
      if (fault_off) to_off_r <= 1'b1;
      else if (!on_req) to_off_r <= 1'b0;
    end
  end

  assign shared_fault_line_out  = 1'b0;
  assign shared_fault_line_oe_n = !fault_off;
  assign alert_line_n = !(to_fault_r || ov_fault_r || decay_flag_r);

  // ****************************************
  // DAC servo and connection
  // ****************************************
  ssm_pkg::ssm_dmode_t dmode;
  logic [CW-1:0] target, target_prev_r;
  logic [15:0]   fast_cnt_r;
  logic          conn_r, matched_r, fast_r, frozen_r, cont, near, warn_out;
  logic [DW-1:0] dac_r;
  assign dmode = ssm_pkg::ssm_dmode_t'(servo_r[`SSM_SV_DMODE_LO +: 2]);
  assign cont  = servo_r[`SSM_SV_CONT];

  // Target select; margin bits have no effect while disconnected
  always_comb begin
    target = vcmd_r;
    if (st_r == ssm_pkg::SEQ_ON && conn_r) begin
      if (onoff_r[`SSM_OP_MG_HI]) target = mhi_r;
      else if (onoff_r[`SSM_OP_MG_LO]) target = mlo_r;
    end
  end

  function automatic logic [CW-1:0] absdiff(input logic [CW-1:0] a, input logic [CW-1:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction
  assign near     = absdiff(vout_code, target) <= CW'(`SSM_NEAR_CODES);
  assign warn_out = vout_code > ovw_r || vout_code < uvw_r;

  // Connection, matching, and servo stepping
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      conn_r <= 1'b0; matched_r <= 1'b0; fast_r <= 1'b0; frozen_r <= 1'b0;
      dac_r <= '0; fast_cnt_r <= 16'h0000; target_prev_r <= '0;
    end else if (clk_en) begin
      target_prev_r <= target;
      if (st_r != ssm_pkg::SEQ_ON || dmode == ssm_pkg::DAC_OPEN) begin
        conn_r <= 1'b0;
        matched_r <= 1'b0;
      end else if (!conn_r && (connect_req_r || matched_r || dmode != ssm_pkg::DAC_SERVO)) begin
        if (dmode == ssm_pkg::DAC_MAN_HC) begin
          conn_r <= 1'b1;
          dac_r  <= dac_reg_r;
        end else if (absdiff(CW'(dac_r), CW'(feedback_code)) <= CW'(1)) begin
          conn_r <= 1'b1;
          fast_r <= !servo_r[`SSM_SV_FASTOFF];
          frozen_r <= 1'b0;
        end else begin
          matched_r <= 1'b1;
          dac_r <= (dac_r < feedback_code) ? dac_r + 1'b1 : dac_r - 1'b1;
        end
      end else if (conn_r && dmode != ssm_pkg::DAC_SERVO) begin
        if (dac_wr) dac_r <= reg_wdata[DW-1:0];
      end else if (conn_r) begin
        if (target != target_prev_r) begin
          fast_r <= !servo_r[`SSM_SV_FASTOFF];
          frozen_r <= 1'b0;
        end else if (fast_r) begin
          fast_cnt_r <= (fast_cnt_r == 16'(FAST_N - 1)) ? 16'h0000 : fast_cnt_r + 16'h0001;
          if (near) fast_r <= 1'b0;
          else if (fast_cnt_r == 16'(FAST_N - 1))
            dac_r <= (vout_code < target) ? dac_r + 1'b1 : dac_r - 1'b1;
        end else if (vout_valid && (cont || !frozen_r)) begin
          if (vout_code == target) frozen_r <= !cont;
          else dac_r <= (vout_code < target) ? dac_r + 1'b1 : dac_r - 1'b1;
        end else if (!cont && frozen_r && servo_r[`SSM_SV_WARN] && vout_valid && warn_out)
          frozen_r <= 1'b0;
      end
    end
  end

  assign dac_code = dac_r;
  assign trim_dac_output_oe_n = !conn_r;

  // ****************************************
  // Register read port
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) reg_rdata <= 16'h0000;
    else if (clk_en && reg_rd) begin
      case (reg_addr)
        `SSM_A_CTRL:   reg_rdata <= {8'h00, ctrl_r};
        `SSM_A_ONOFF:  reg_rdata <= {8'h00, onoff_r};
        `SSM_A_SERVO:  reg_rdata <= {8'h00, servo_r};
        `SSM_A_VCMD:   reg_rdata <= 16'(vcmd_r);
        `SSM_A_DAC:    reg_rdata <= 16'(dac_r);
        `SSM_A_STATUS: reg_rdata <= {11'h000, conn_r, st_r == ssm_pkg::SEQ_ON,
                                     decay_flag_r, ov_fault_r, to_fault_r};
        default:       reg_rdata <= 16'h0000;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_enable_off_state: assert property (@(posedge core_clk) disable iff (!rst_n)
    st_r == ssm_pkg::SEQ_OFF |-> !vout_enable) else $error("enable high in off");
  chk_vin_gate_on: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && st_r == ssm_pkg::SEQ_OFF && !vin_ok_r |=> st_r == ssm_pkg::SEQ_OFF)
    else $error("started below input threshold");
  chk_disc_no_oe: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && dmode == ssm_pkg::DAC_OPEN ##1 dmode == ssm_pkg::DAC_OPEN |-> trim_dac_output_oe_n)
    else $error("dac driven while disconnected");
  chk_decay_alert: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && st_r == ssm_pkg::SEQ_OFF && on_req && !decayed |=> !alert_line_n)
    else $error("decay hold without alert");
  chk_fault_pull_line: assert property (@(posedge core_clk) disable iff (!rst_n)
    fault_off |-> !shared_fault_line_oe_n && !shared_fault_line_out)
    else $error("fault line not pulled");
  chk_margin_disc_ign: assert property (@(posedge core_clk) disable iff (!rst_n)
    !conn_r |-> target == vcmd_r) else $error("margin applied while disconnected");
  chk_rise_to_on: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && st_r == ssm_pkg::SEQ_RISE && cnt_r == 16'h0000 && !fault_off && on_req
    && !fault_line_low |=> st_r == ssm_pkg::SEQ_ON) else $error("rise end missed");
  chk_ov_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    clk_en && ov_now && !margin_ov_ignore |=> ov_fault_r) else $error("ov not flagged");
  cov_reach_on: cover property (@(posedge core_clk) st_r == ssm_pkg::SEQ_ON);
  cov_connect: cover property (@(posedge core_clk) $rose(conn_r));
  cov_timeout: cover property (@(posedge core_clk) $rose(to_fault_r));

endmodule // ssm_channel

/* File: sim/ssm_conv_model.sv */
// Behavioural converter and input-voltage sense facing one supply channel.
// Assumes one core_clk; a conversion pair repeats every 16 cycles.
`timescale 1ns/1ps
module ssm_conv_model (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Controls from the channel and the bench
  input  wire logic        en,
  input  wire logic        hold_up,
  input  wire logic        oe_n,
  input  wire logic [9:0]  dac,
  input  wire logic [15:0] vin_level,
  // Measurements back to the channel
  output logic      [15:0] vout,
  output logic             vout_valid,
  output logic      [15:0] vin_code,
  output logic             vin_valid,
  output logic      [9:0]  fb
);
  logic [3:0] cnt_r;

  // Fast ramp and decay keep the bench short; hold_up holds the output with no decay
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 4'h0;
      vout  <= 16'h0000;
    end else begin
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r == 4'h0) begin
        if (en) vout <= 16'h1000;
        else if (!hold_up) vout <= (vout >= 16'h0400) ? vout - 16'h0400 : 16'h0000;
      end
    end
  end

  // Strobes on separate phases, as a multiplexed converter would give
  assign vout_valid = (cnt_r == 4'h1);
  assign vin_valid  = (cnt_r == 4'h9);
  assign vin_code   = vin_level;
  assign fb         = oe_n ? 10'h200 : dac; // Node follows the DAC once joined
endmodule // ssm_conv_model

/* File: sim/supply_sequence_servo_margin_bench.sv */
// Self-checking bench for one supply channel: gating, sequencing, decay hold, servo, timeout.
// Assumes the converter model beside it and the constants header on the path.
`timescale 1ns/1ps
`include "ssm_consts.svh"
module supply_sequence_servo_margin_bench;
  logic core_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, control_pin = 0, hold_up = 0;
  logic run = 1, mg_ign = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, vin_level = 16'h0000, vin_code, vout, d;
  logic vin_valid, vout_valid, vout_enable, oe_n, f_out, f_oe_n, alert_line_n;
  logic [9:0] dac_code, fb;
  int fail_count = 0, num_checks = 0, n;
  logic [1:0] good [4] = '{2'b00, 2'b10, 2'b01, 2'b11}; // {command, pin}
  logic [1:0] bad  [4] = '{2'b00, 2'b01, 2'b10, 2'b10};

  // Clock; the fault wire is pulled up when nobody pulls it low
  always #2.5 core_clk = ~core_clk;
  wire fault_wire = f_oe_n ? 1'b1 : f_out;

  ssm_channel i_dut (.core_clk(core_clk), .nrst(nrst), .clk_en(run), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .input_voltage_sense(vin_code), .vin_valid(vin_valid), .vout_code(vout),
    .vout_valid(vout_valid), .feedback_code(fb), .control_pin(control_pin),
    .margin_ov_ignore(mg_ign), .vout_enable(vout_enable), .dac_code(dac_code),
    .trim_dac_output_oe_n(oe_n), .shared_fault_line_in(fault_wire),
    .shared_fault_line_out(f_out), .shared_fault_line_oe_n(f_oe_n),
    .alert_line_n(alert_line_n));
  ssm_conv_model i_conv (.core_clk(core_clk), .nrst(nrst), .en(vout_enable),
    .hold_up(hold_up), .oe_n(oe_n), .dac(dac_code), .vin_level(vin_level), .vout(vout),
    .vout_valid(vout_valid), .vin_code(vin_code), .vin_valid(vin_valid), .fb(fb));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic wrap_up();
    if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
      fail_count++;
    end
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] v);
    @(posedge core_clk);
    reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, output logic [15:0] v);
    @(posedge core_clk);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    // Data launched at this edge is taken at the next one, while it still stands
    @(posedge core_clk);
    v = reg_rdata;
  endtask
  // Waits, bounded, for the converter enable to reach a level
  task automatic wait_en(logic lvl, output int cyc);
    for (cyc = 0; vout_enable !== lvl; cyc++) begin
      if (cyc > 1200) begin
        chk("enable wait", 16'h0000, 16'h0001);
        wrap_up();
      end
      @(posedge core_clk);
    end
  endtask
  // Command on/off with a bounded decay wait afterwards
  task automatic go(logic [15:0] op, logic lvl);
    wr(`SSM_A_ONOFF, op);
    wait_en(lvl, n);
    repeat (100) @(posedge core_clk);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic s_reset();
    chk("enable at reset", vout_enable, 1'b0);
    rd(`SSM_A_SERVO, d); chk("servo reset", d, `SSM_SERVO_RST);
    rd(`SSM_A_CTRL, d); chk("ctrl reset", d, `SSM_CTRL_RST);
    rd(8'h40, d); chk("unmapped read", d, 16'h0000);
    // A write while the clock enable is low must leave the register alone
    run <= 1'b0;
    wr(`SSM_A_SERVO, 16'h00ff);
    run <= 1'b1;
    rd(`SSM_A_SERVO, d); chk("write while frozen", d, `SSM_SERVO_RST);
  endtask
  task automatic s_gate();
    wr(`SSM_A_CTRL, 16'h0001); wr(`SSM_A_TON, 16'h0002); wr(`SSM_A_ONOFF, 16'h0080);
    repeat (500) @(posedge core_clk);
    chk("enable below vin on", vout_enable, 1'b0);
    vin_level <= 16'd200;
    wait_en(1'b1, n);
    chk("turn-on delay", (n >= 200 && n <= 420), 1'b1);
    chk("dac open", oe_n, 1'b1);
    wr(`SSM_A_ONOFF, 16'h0000);
    wait_en(1'b0, n);
    chk("turn-off delay", (n >= 1 && n <= 202), 1'b1);
    repeat (100) @(posedge core_clk);
    go(16'h0080, 1'b1);
    vin_level <= 16'd10;
    wait_en(1'b0, n);
    chk("vin loss off", (n <= 24), 1'b1);
    vin_level <= 16'd200;
    wr(`SSM_A_TON, 16'h0001);
    go(16'h0000, 1'b0);
    // Delayed-off mode: input loss runs the two-tick off delay
    wr(`SSM_A_CTRL, 16'h0005);
    wr(`SSM_A_TOFF, 16'h0002);
    go(16'h0080, 1'b1);
    vin_level <= 16'd10;
    wait_en(1'b0, n);
    chk("vin loss delayed off", (n >= 200 && n <= 420), 1'b1);
    go(16'h0000, 1'b0);
    vin_level <= 16'd200;
    wr(`SSM_A_TOFF, 16'h0001);
    wr(`SSM_A_CTRL, 16'h0001);
  endtask
  task automatic s_modes();
    for (int i = 0; i < 4; i++) begin
      wr(`SSM_A_CTRL, 16'(i));
      if (i > 0) begin
        wr(`SSM_A_ONOFF, {8'h00, bad[i][1], 7'h00}); control_pin <= bad[i][0];
        repeat (500) @(posedge core_clk);
        chk("wrong condition", vout_enable, 1'b0);
      end
      control_pin <= good[i][0];
      wr(`SSM_A_ONOFF, {8'h00, good[i][1], 7'h00});
      wait_en(1'b1, n);
      chk("right condition", vout_enable, 1'b1);
      control_pin <= 1'b0;
      wr(`SSM_A_CTRL, 16'h0001);
      go(16'h0000, 1'b0);
    end
  endtask
  task automatic s_decay();
    go(16'h0080, 1'b1);
    hold_up <= 1'b1;
    go(16'h0000, 1'b0);
    wr(`SSM_A_ONOFF, 16'h0080);
    repeat (600) @(posedge core_clk);
    chk("held off", vout_enable, 1'b0);
    chk("alert low", alert_line_n, 1'b0);
    rd(`SSM_A_STATUS, d); chk("decay status", d[2], 1'b1);
    hold_up <= 1'b0;
    wait_en(1'b1, n);
    wr(`SSM_A_CLEAR, 16'h0001);
    rd(`SSM_A_STATUS, d); chk("decay cleared", d[2], 1'b0);
    chk("alert released", alert_line_n, 1'b1);
  endtask
  task automatic s_servo();
    go(16'h0000, 1'b0);
    wr(`SSM_A_SERVO, 16'h0020);
    wr(`SSM_A_MHI, 16'h1100);
    go(16'h0080, 1'b1);
    for (n = 0; oe_n !== 1'b0 && n < 1200; n++) @(posedge core_clk);
    chk("dac joined", oe_n, 1'b0);
    if (n >= 1200) wrap_up();
    // Node sits at 0x200 before joining, so the code must be within one of it
    chk("join code", (dac_code >= 10'h1ff && dac_code <= 10'h201), 1'b1);
    wr(`SSM_A_ONOFF, 16'h00a0);
    repeat (64) @(posedge core_clk);
    chk("margin moves dac", (dac_code != 10'h1ff), 1'b1);
    mg_ign <= 1'b1;
    wr(`SSM_A_OVF, 16'h0f00);
    repeat (4) @(posedge core_clk);
    rd(`SSM_A_STATUS, d); chk("ov ignored", d[1], 1'b0);
    mg_ign <= 1'b0;
    repeat (2) @(posedge core_clk);
    rd(`SSM_A_STATUS, d); chk("ov flagged", d[1], 1'b1);
    wr(`SSM_A_OVF, 16'hffff);
    wr(`SSM_A_CLEAR, 16'h0001);
    rd(`SSM_A_STATUS, d); chk("ov cleared", d[1], 1'b0);
  endtask
  task automatic s_timeout();
    go(16'h0000, 1'b0);
    wr(`SSM_A_UVF, 16'h2000);
    wr(`SSM_A_TMAX, 16'h0003);
    wr(`SSM_A_CTRL, 16'h0009);
    go(16'h0080, 1'b1);
    wait_en(1'b0, n);
    chk("fault line pulled", f_oe_n, 1'b0);
    chk("timeout alert", alert_line_n, 1'b0);
    rd(`SSM_A_STATUS, d); chk("timeout status", d[0], 1'b1);
    wr(`SSM_A_CLEAR, 16'h0001);
    rd(`SSM_A_STATUS, d); chk("timeout cleared", d[0], 1'b0);
    chk("fault line released", f_oe_n, 1'b1);
  endtask

  // Reset for three cycles, the reset scenario, then the setup and the other scenarios
  initial begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    s_reset();
    wr(`SSM_A_VINON, 16'd100); wr(`SSM_A_VINOFF, 16'd50); wr(`SSM_A_VCMD, 16'h1000);
    wr(`SSM_A_DISCH, 16'h0080); wr(`SSM_A_OVF, 16'hffff); wr(`SSM_A_OVW, 16'hffff);
    wr(`SSM_A_TMAX, 16'h0100); wr(`SSM_A_TRISE, 16'h0001); wr(`SSM_A_TOFF, 16'h0001);
    wr(`SSM_A_SERVO, 16'h0001);
    s_gate();
    s_modes();
    s_decay();
    s_servo();
    s_timeout();
    wrap_up();
  end
endmodule // supply_sequence_servo_margin_bench
